// *** include/wkt_regs.vh ***
// register map, field positions and reset values of the wake-up timer
// What this block does
// - running bit shows counting, written only with qualifier
// - qualifier is write-only enable for running bit
// - auto trim launches oscillator trimming at underflow
// - auto detect runs card detection, card raises irq
// - no card found enters power-down when enabled
// - third general timer governs field-on time
// - auto reload or auto detect restarts from reload, else stops
// - every underflow sets the underflow flag
// - auto wake leaves low power at underflow
// - power-down return only when auto wake set
// - clock select: undivided, /8, /16, /32
// - reload word copied into counter at start and at each restart
// - two read-only bytes show live counter value
`ifndef WKT_REGS_VH
`define WKT_REGS_VH
// printed offsets are not multiples of four: byte address = 4 * index
`define WKT_IDX_CONTROL     6'h23
`define WKT_IDX_RELOAD_HI   6'h24
`define WKT_IDX_RELOAD_LO   6'h25
`define WKT_IDX_COUNT_HI    6'h26
`define WKT_IDX_COUNT_LO    6'h27
`define WKT_IDX_IRQ_STATUS  6'h30
`define WKT_IDX_IRQ_MASK    6'h31
// control register fields
`define WKT_BIT_RUNNING     7
`define WKT_BIT_QUALIFIER   6
`define WKT_BIT_AUTO_TRIM   5
`define WKT_BIT_AUTO_DETECT 4
`define WKT_BIT_AUTO_RELOAD 3
`define WKT_BIT_AUTO_WAKE   2
// status / mask fields
`define WKT_IRQ_UNDERFLOW   0
`define WKT_IRQ_CARD        1
`define WKT_IRQ_NOCARD      2
`define WKT_CTRL_RESET      6'h00
`define WKT_RELOAD_RESET    16'h0000
`define WKT_IRQ_RESET       3'h0
// last prescaler count per clock select
`define WKT_DIV_LAST_1      5'h00
`define WKT_DIV_LAST_8      5'h07
`define WKT_DIV_LAST_16     5'h0f
`define WKT_DIV_LAST_32     5'h1f
`endif

// *** src/wkt_wakeup_timer.v ***
// wake-up timer with auto trim / card detection sequencing and avalon-mm slave
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "wkt_regs.vh"
module wkt_wakeup_timer (
  input  wire        clk,
  input  wire        nrst,
  // avalon-mm slave
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  output wire [1:0]  response,
  // slow oscillator clock level, asynchronous to clk
  input  wire        slowOscillator,
  // trimming procedure handshake
  output reg         trimStart,
  input  wire        trimDone,
  // card detection sequence handshake; field time is set by the third timer
  output reg         cardDetectStart,
  input  wire        cardDetectDone,
  input  wire        cardFound,
  // power management
  output reg         wakeRequest,
  output reg         powerDownRequest,
  output wire        irq
);

  // --------------------------------------------------------------
  // local state
  // --------------------------------------------------------------
  localparam [1:0] SEQ_IDLE  = 2'd0;
  localparam [1:0] SEQ_TRIM  = 2'd1;
  localparam [1:0] SEQ_CARD  = 2'd2;

  reg  [5:0]  ctrl;
  reg         running;
  reg  [15:0] reloadWord;
  reg  [15:0] count;
  reg  [2:0]  irqStatus;
  reg  [2:0]  irqMask;
  reg  [1:0]  seqState;
  reg         seqCard;
  reg         oscMeta;
  reg         oscSync;
  reg         oscPrev;
  reg  [4:0]  divCount;
  reg         ackPhase;

  wire [5:0]  regIdx = address[7:2];
  wire        addrOk = (address[1:0] == 2'b00);
  wire        wrLow  = write & byteenable[0] & addrOk & ackPhase;

  // --------------------------------------------------------------
  // bus slave: one wait state, answer on second edge
  // --------------------------------------------------------------
  function mapped;
    input [5:0] idx;
    begin
      case (idx)
        `WKT_IDX_CONTROL,
        `WKT_IDX_RELOAD_HI,
        `WKT_IDX_RELOAD_LO,
        `WKT_IDX_COUNT_HI,
        `WKT_IDX_COUNT_LO,
        `WKT_IDX_IRQ_STATUS,
        `WKT_IDX_IRQ_MASK: mapped = 1'b1;
        default:           mapped = 1'b0;
      endcase
    end
  endfunction

  assign waitrequest = (read | write) & ~ackPhase;
  assign response    = (ackPhase && !(mapped(regIdx) && addrOk)) ? 2'b11 : 2'b00;
  assign irq         = |(irqStatus & irqMask);

  // --------------------------------------------------------------
  // bus handshake
  // --------------------------------------------------------------
  // every request waits exactly one cycle, reads and writes alike
  wire next_ackPhase = (read | write) & ~ackPhase;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ackPhase <= 1'b0;
    end else begin
      ackPhase <= next_ackPhase;
    end
  end

  // --------------------------------------------------------------
  // read data mux
  // --------------------------------------------------------------
  // count bytes are live, not latched: a tick may fall between them
  function [7:0] regByte;
    input [5:0] idx;
    begin
      case (idx)
        `WKT_IDX_CONTROL:    regByte = {running, 1'b0, ctrl};
        `WKT_IDX_RELOAD_HI:  regByte = reloadWord[15:8];
        `WKT_IDX_RELOAD_LO:  regByte = reloadWord[7:0];
        `WKT_IDX_COUNT_HI:   regByte = count[15:8];
        `WKT_IDX_COUNT_LO:   regByte = count[7:0];
        `WKT_IDX_IRQ_STATUS: regByte = {5'h00, irqStatus};
        `WKT_IDX_IRQ_MASK:   regByte = {5'h00, irqMask};
        default:             regByte = 8'h00;
      endcase
    end
  endfunction

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= 32'h00000000;
    end else if (read & ~ackPhase) begin
      readdata <= {24'h000000, regByte(regIdx)};
    end
  end

  // --------------------------------------------------------------
  // slow oscillator sync
  // --------------------------------------------------------------
  // two flops against metastability, a third only for edge detection
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oscMeta <= 1'b0;
      oscSync <= 1'b0;
      oscPrev <= 1'b0;
    end else begin
      oscMeta <= slowOscillator;
      oscSync <= oscMeta;
      oscPrev <= oscSync;
    end
  end

  wire oscEdge = oscSync & ~oscPrev;

  // --------------------------------------------------------------
  // prescaler
  // --------------------------------------------------------------
  function [4:0] divLast;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   divLast = `WKT_DIV_LAST_1;
        2'b01:   divLast = `WKT_DIV_LAST_8;
        2'b10:   divLast = `WKT_DIV_LAST_16;
        default: divLast = `WKT_DIV_LAST_32;
      endcase
    end
  endfunction

  wire tick = oscEdge && (divCount >= divLast(ctrl[1:0]));

  // cleared while stopped, so the first period after a start is whole
  reg  [4:0]  next_divCount;
  always @* begin
    next_divCount = divCount;
    if (!running) begin
      next_divCount = 5'h00;
    end else if (tick) begin
      next_divCount = 5'h00;
    end else if (oscEdge) begin
      next_divCount = divCount + 5'h01;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      divCount <= 5'h00;
    end else begin
      divCount <= next_divCount;
    end
  end

  // --------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------
  // one write decode shared by every writable register
  function wrHit;
    input [5:0] idx;
    begin
      wrHit = wrLow && (regIdx == idx);
    end
  endfunction

  wire underflow = running && tick && (count == 16'h0000);
  wire ctrlWr    = wrHit(`WKT_IDX_CONTROL);
  wire startCmd  = ctrlWr && writedata[`WKT_BIT_QUALIFIER] &&
                   writedata[`WKT_BIT_RUNNING];
  wire stopCmd   = ctrlWr && writedata[`WKT_BIT_QUALIFIER] &&
                   !writedata[`WKT_BIT_RUNNING];
  // card detection forces a gapless restart even without auto reload
  wire restart   = ctrl[`WKT_BIT_AUTO_RELOAD] || ctrl[`WKT_BIT_AUTO_DETECT];

  // running and qualifier live elsewhere: the qualifier reads back 0
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= `WKT_CTRL_RESET;
    end else if (ctrlWr) begin
      ctrl <= writedata[5:0];
    end
  end

  // new reload bytes wait for the next start or restart
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reloadWord <= `WKT_RELOAD_RESET;
    end else if (wrHit(`WKT_IDX_RELOAD_HI)) begin
      reloadWord[15:8] <= writedata[7:0];
    end else if (wrHit(`WKT_IDX_RELOAD_LO)) begin
      reloadWord[7:0] <= writedata[7:0];
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqMask <= `WKT_IRQ_RESET;
    end else if (wrHit(`WKT_IDX_IRQ_MASK)) begin
      irqMask <= writedata[2:0];
    end
  end

  // --------------------------------------------------------------
  // countdown
  // --------------------------------------------------------------
  reg         next_running;
  reg  [15:0] next_count;
  always @* begin
    next_running = running;
    next_count   = count;
    if (startCmd) begin
      next_running = 1'b1;
      next_count   = reloadWord;
    end else if (stopCmd) begin
      next_running = 1'b0;
    end else if (underflow) begin
      next_running = restart;
      if (restart) begin
        next_count = reloadWord;
      end else begin
        next_count = 16'h0000;
      end
    end else if (running && tick) begin
      next_count = count - 16'h0001;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      running <= 1'b0;
      count   <= `WKT_RELOAD_RESET;
    end else begin
      running <= next_running;
      count   <= next_count;
    end
  end

  // --------------------------------------------------------------
  // interrupt status
  // --------------------------------------------------------------
  // a hardware set in the clearing cycle wins, so no event is lost
  wire cardDone = (seqState == SEQ_CARD) && cardDetectDone;
  reg  [2:0]  next_irqStatus;
  always @* begin
    next_irqStatus = irqStatus;
    if (wrHit(`WKT_IDX_IRQ_STATUS)) begin
      next_irqStatus = irqStatus & ~writedata[2:0];
    end
    if (underflow) begin
      next_irqStatus[`WKT_IRQ_UNDERFLOW] = 1'b1;
    end
    if (cardDone && cardFound) begin
      next_irqStatus[`WKT_IRQ_CARD] = 1'b1;
    end
    if (cardDone && !cardFound) begin
      next_irqStatus[`WKT_IRQ_NOCARD] = 1'b1;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqStatus <= `WKT_IRQ_RESET;
    end else begin
      irqStatus <= next_irqStatus;
    end
  end

  // --------------------------------------------------------------
  // automatic procedures: next state
  // --------------------------------------------------------------
  reg  [1:0]  next_seqState;
  reg         next_seqCard;
  reg         next_trimStart;
  reg         next_cardDetectStart;
  reg         next_wakeRequest;
  reg         next_powerDownRequest;
  // underflows during a running procedure start no second one
  always @* begin
    next_seqState         = seqState;
    next_seqCard          = seqCard;
    next_trimStart        = 1'b0;
    next_cardDetectStart  = 1'b0;
    next_wakeRequest      = 1'b0;
    next_powerDownRequest = 1'b0;
    case (seqState)
      SEQ_IDLE: begin
        if (underflow) begin
          next_wakeRequest = ctrl[`WKT_BIT_AUTO_WAKE];
          next_seqCard     = ctrl[`WKT_BIT_AUTO_DETECT];
          if (ctrl[`WKT_BIT_AUTO_TRIM]) begin
            next_trimStart = 1'b1;
            next_seqState  = SEQ_TRIM;
          end else if (ctrl[`WKT_BIT_AUTO_DETECT]) begin
            next_cardDetectStart = 1'b1;
            next_seqState        = SEQ_CARD;
          end
        end
      end
      SEQ_TRIM: begin
        // trimming first, then detection; both done back to back
        if (trimDone) begin
          if (seqCard) begin
            next_cardDetectStart = 1'b1;
            next_seqState        = SEQ_CARD;
          end else begin
            next_powerDownRequest = ctrl[`WKT_BIT_AUTO_WAKE];
            next_seqState         = SEQ_IDLE;
          end
        end
      end
      SEQ_CARD: begin
        if (cardDetectDone) begin
          next_powerDownRequest = !cardFound && ctrl[`WKT_BIT_AUTO_WAKE];
          next_seqState         = SEQ_IDLE;
        end
      end
      default: begin
        next_seqState = SEQ_IDLE;
      end
    endcase
  end

  // --------------------------------------------------------------
  // automatic procedures: registers
  // --------------------------------------------------------------
  // requests leave flops, one clean single-cycle pulse each
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seqState         <= SEQ_IDLE;
      seqCard          <= 1'b0;
      trimStart        <= 1'b0;
      cardDetectStart  <= 1'b0;
      wakeRequest      <= 1'b0;
      powerDownRequest <= 1'b0;
    end else begin
      seqState         <= next_seqState;
      seqCard          <= next_seqCard;
      trimStart        <= next_trimStart;
      cardDetectStart  <= next_cardDetectStart;
      wakeRequest      <= next_wakeRequest;
      powerDownRequest <= next_powerDownRequest;
    end
  end

endmodule // wkt_wakeup_timer

// *** test/wkt_properties.sv ***
// port checker for the wake-up timer
`timescale 1ns/1ps
module wkt_properties (
  input logic        clk,
  input logic        nrst,
  input logic [7:0]  address,
  input logic        read,
  input logic        write,
  input logic [31:0] readdata,
  input logic        waitrequest,
  input logic [1:0]  response,
  input logic        trimStart,
  input logic        trimDone,
  input logic        cardDetectStart,
  input logic        cardDetectDone,
  input logic        cardFound,
  input logic        wakeRequest,
  input logic        powerDownRequest
);
  logic [2:0] doneAge;
  // age saturates so a stale done cannot excuse a late power-down
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) doneAge <= 3'h7;
    else if (trimDone | cardDetectDone) doneAge <= 3'h0;
    else if (doneAge != 3'h7) doneAge <= doneAge + 3'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence firstCycle;
    (read | write) && waitrequest;
  endsequence
  sequence answered;
    (read | write) && !waitrequest;
  endsequence
  chk_wait_first: assert property ($rose(read | write) |-> waitrequest)
    else $error("no wait state");
  chk_one_wait: assert property (firstCycle |=> answered)
    else $error("answer late");
  chk_wake_pulse: assert property (wakeRequest |=> !wakeRequest)
    else $error("wake not a pulse");
  chk_trim_pulse: assert property (trimStart |=> !trimStart)
    else $error("trim start not a pulse");
  chk_start_excl: assert property (!(trimStart && cardDetectStart))
    else $error("trim and detect together");
  chk_pd_cause: assert property (powerDownRequest |-> doneAge < 3'h6)
    else $error("power-down without done");
  chk_card_stays: assert property (cardDetectDone && cardFound |=> !powerDownRequest [*4])
    else $error("power-down after card");
  chk_count_ok: assert property ((read | write) && !waitrequest && address[7:3] == 5'h13
    |-> response == 2'b00)
    else $error("count read refused");
  chk_unmapped: assert property (read && !waitrequest && address[7:2] == 6'h3f
    |-> response == 2'b11 && readdata == 32'h0)
    else $error("unmapped read wrong");
endmodule // wkt_properties
bind wkt_wakeup_timer wkt_properties chk_i (.clk(clk), .nrst(nrst), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .response(response), .trimStart(trimStart), .trimDone(trimDone),
  .cardDetectStart(cardDetectStart), .cardDetectDone(cardDetectDone),
  .cardFound(cardFound), .wakeRequest(wakeRequest), .powerDownRequest(powerDownRequest));

// *** test/wkt_tb.sv ***
// self-checking bench for the wake-up timer
`timescale 1ns/1ps
module tb;
  logic        clk, nrst, read, write, slowOscillator, trimDone, cardDetectDone, cardFound;
  logic [7:0]  address, q;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  logic [1:0]  response;
  logic        waitrequest, trimStart, cardDetectStart, wakeRequest, powerDownRequest, irq;
  int          n_fail, check_count, nWake, nPd, nTrim, nCard, b;
  wkt_wakeup_timer dut (.clk(clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .slowOscillator(slowOscillator),
    .trimStart(trimStart), .trimDone(trimDone), .cardDetectStart(cardDetectStart),
    .cardDetectDone(cardDetectDone), .cardFound(cardFound), .wakeRequest(wakeRequest),
    .powerDownRequest(powerDownRequest), .irq(irq));
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // slow clock of 8 clk periods, edges on falling clk edges, away from rising ones
  initial begin
    slowOscillator = 0;
    forever #160 slowOscillator = ~slowOscillator;
  end
  always @(negedge clk) begin
    nWake += (wakeRequest === 1'b1);
    nPd += (powerDownRequest === 1'b1);
    nTrim += (trimStart === 1'b1);
    nCard += (cardDetectStart === 1'b1);
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input [7:0] got, input [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up;
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(input [5:0] i, input w, input [7:0] d);
    int n;
    address <= {i, 2'b00};
    read <= !w;
    write <= w;
    writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata[7:0];
    read <= 0;
    write <= 0;
    @(posedge clk);
    if (n >= 20) begin
      n_fail++;
      wrap_up;
    end
  endtask
  task automatic waitEv(ref int c, input int base);
    int n;
    n = 0;
    while (c == base && n < 600) begin
      @(posedge clk);
      n++;
    end
    if (n >= 600) begin
      n_fail++;
      wrap_up;
    end
  endtask
  task pulseDone(input card, input found);
    cardFound <= found;
    cardDetectDone <= card;
    trimDone <= !card;
    @(posedge clk);
    cardDetectDone <= 0;
    trimDone <= 0;
  endtask
  task sc_reset;
    bus(6'h23, 0, 0); chk(q, 8'h00);
    bus(6'h24, 0, 0); chk(q, 8'h00);
    bus(6'h3f, 0, 0); chk(q, 8'h00);
    bus(6'h23, 1, 8'h80); bus(6'h23, 0, 0); chk(q, 8'h00);
  endtask
  task sc_oneshot;
    bus(6'h31, 1, 8'h01); bus(6'h25, 1, 8'h03);
    b = nWake; bus(6'h23, 1, 8'hc4); bus(6'h23, 0, 0); chk(q, 8'h84);
    bus(6'h25, 1, 8'h09); bus(6'h27, 0, 0); chk({7'h0, q <= 8'h03}, 8'h01);
    waitEv(nWake, b); repeat (4) @(posedge clk);
    bus(6'h23, 0, 0); chk(q, 8'h04);
    bus(6'h27, 0, 0); chk(q, 8'h00);
    chk(irq, 1); bus(6'h31, 1, 8'h00); chk(irq, 0);
    bus(6'h31, 1, 8'h01); chk(irq, 1); bus(6'h30, 1, 8'h01); chk(irq, 0);
  endtask
  task sc_card;
    bus(6'h25, 1, 8'h02); b = nCard; bus(6'h23, 1, 8'hd4); waitEv(nCard, b);
    b = nPd; pulseDone(1, 0); waitEv(nPd, b);
    bus(6'h30, 0, 0); chk(q & 8'h04, 8'h04);
    bus(6'h23, 0, 0); chk(q, 8'h94); b = nCard; waitEv(nCard, b);
    b = nPd; pulseDone(1, 1); bus(6'h30, 0, 0); chk(q & 8'h02, 8'h02);
    bus(6'h23, 1, 8'h54); chk(8'(nPd - b), 8'h00);
    bus(6'h23, 0, 0); chk(q, 8'h14);
  endtask
  task sc_trim;
    b = nTrim; bus(6'h23, 1, 8'he4); waitEv(nTrim, b);
    b = nPd; pulseDone(0, 0); waitEv(nPd, b); bus(6'h23, 1, 8'h40);
    b = nTrim; bus(6'h23, 1, 8'he0); waitEv(nTrim, b);
    b = nPd; pulseDone(0, 0); repeat (8) @(posedge clk);
    chk(8'(nPd - b), 8'h00); bus(6'h23, 1, 8'h40);
  endtask
  task sc_div;
    bus(6'h25, 1, 8'h01); b = nWake; bus(6'h23, 1, 8'hc7);
    repeat (150) @(posedge clk); chk(8'(nWake - b), 8'h00);
    waitEv(nWake, b); chk(8'(nWake - b), 8'h01);
    b = nWake; bus(6'h23, 1, 8'hc5);
    repeat (50) @(posedge clk); chk(8'(nWake - b), 8'h00);
    waitEv(nWake, b); chk(8'(nWake - b), 8'h01);
  endtask
  initial begin
    nrst = 0; read = 0; write = 0; address = 0; writedata = 0; byteenable = 4'hf;
    trimDone = 0; cardDetectDone = 0; cardFound = 0;
    repeat (20) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    sc_reset; sc_oneshot; sc_card; sc_trim; sc_div;
    wrap_up;
  end
endmodule // tb
